// file: rtl/peripheral_clock_rate_select.sv
// clock-rate selection registers and tick generators for core and peripherals
`timescale 1ns/1ps
`default_nettype none
module peripheral_clock_rate_select
  import clk_rate_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic security_double_speed_in,
  input wire logic [1:0] uart_mode_in,
  output logic double_speed_out,
  output logic core_tick_out,
  output logic [6:0] periph_tick_out,
  output logic uart_tick_out
);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [6:1] main_sel_ff;
  logic double_speed_ff;
  logic spi_sel_ff;

  wire req = avs_read_in | avs_write_in;
  // first edge of a request registers read data and drops waitrequest
  wire accept = req & wait_ff;
  // second edge, seen with waitrequest low, completes the transfer
  wire finish = req & ~wait_ff;
  wire hit_main = (avs_address_in == MAIN_ADDR);
  wire hit_serial = (avs_address_in == SERIAL_ADDR);
  // a write lands only at the completing edge, where the master ends it
  wire wr_lane0 = finish & avs_write_in & avs_byteenable_in[0];
  wire wr_main = wr_lane0 & hit_main;
  wire wr_serial = wr_lane0 & hit_serial;
  // reserved bit 7 is not stored and reads as zero
  wire [7:0] main_view = {1'b0, main_sel_ff, double_speed_ff};
  wire [7:0] serial_view = {7'h00, spi_sel_ff};
  wire [31:0] nxt_rdata = hit_main ? {24'h000000, main_view} :
                          hit_serial ? {24'h000000, serial_view} : 32'h00000000;
  wire load_rdata = accept & avs_read_in;

  // waitrequest is low for exactly one cycle per request
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= ~accept;
    end
  end

  // read data stand from the answer cycle until the next read
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_ff <= 32'h00000000;
    end else if (load_rdata) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_readdata_out = rdata_ff;
  assign avs_waitrequest_out = wait_ff;

  ////////////////////////////////////////////////////////////////////////////
  // security strap capture

  logic strap_meta_ff;
  logic strap_sync_ff;
  logic [1:0] settle_ff;
  logic loaded_ff;
  // the strap is a pin level, so it is synchronised before it is trusted
  wire strap_load = ~loaded_ff & (settle_ff == STRAP_SETTLE);

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      strap_meta_ff <= 1'b0;
      strap_sync_ff <= 1'b0;
    end else begin
      strap_meta_ff <= security_double_speed_in;
      strap_sync_ff <= strap_meta_ff;
    end
  end

  // the settle count lets the synchroniser fill before the strap is used
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      settle_ff <= 2'h0;
    end else if (!loaded_ff && settle_ff != STRAP_SETTLE) begin
      settle_ff <= settle_ff + 2'h1;
    end
  end

  // one load per reset, so later writes own the bit
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      loaded_ff <= 1'b0;
    end else if (strap_load) begin
      loaded_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      main_sel_ff <= MAIN_SEL_RESET;
    end else if (wr_main) begin
      main_sel_ff <= avs_writedata_in[BIT_WATCHDOG:BIT_TIMER0];
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      double_speed_ff <= 1'b0;
    end else if (strap_load) begin
      // strap load beats a racing write
      double_speed_ff <= strap_sync_ff;
    end else if (wr_main) begin
      double_speed_ff <= avs_writedata_in[BIT_DOUBLE_SPEED];
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      spi_sel_ff <= SERIAL_RESET;
    end else if (wr_serial) begin
      spi_sel_ff <= avs_writedata_in[BIT_SPI];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // glitch-free double-speed switch

  logic half_ff;
  logic speed_eff_ff;

  // half_ff low marks the edge on which the oscillator/2 phase rises
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      half_ff <= 1'b0;
      speed_eff_ff <= 1'b0;
    end else begin
      half_ff <= ~half_ff;
      // sample only as the half-rate clock rises
      if (!half_ff) begin
        speed_eff_ff <= double_speed_ff;
      end
    end
  end

  assign double_speed_out = speed_eff_ff;

  ////////////////////////////////////////////////////////////////////////////
  // tick generators

  // core channel has no select of its own, so it rides a constant zero
  wire [NUM_CH-1:0] sel_vec = {1'b0, spi_sel_ff, main_sel_ff};
  wire [NUM_CH-1:0] ticks;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      // select gated by double-speed; zero means fast
      wire fast = speed_eff_ff & ~sel_vec[ch];
      rate_divider u_div (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .fast_in(fast),
        .tick_out(ticks[ch])
      );
    end
  endgenerate

  assign core_tick_out = ticks[CH_CORE];
  assign periph_tick_out = ticks[NUM_CH-2:0];

  ////////////////////////////////////////////////////////////////////////////
  // uart clock by serial mode

  logic uart_tick_ff;
  // modes 0 and 2 use the selectable uart rate
  wire uart_sel_mode = (uart_mode_in == 2'h0) | (uart_mode_in == 2'h2);
  wire nxt_uart_tick = uart_sel_mode ? ticks[CH_UART] : ticks[CH_CORE];

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      uart_tick_ff <= 1'b0;
    end else begin
      uart_tick_ff <= nxt_uart_tick;
    end
  end

  assign uart_tick_out = uart_tick_ff;
endmodule
`default_nettype wire

// file: rtl/clk_rate_pkg.sv
// constants for the peripheral clock-rate selection block
package clk_rate_pkg;
  // avalon address is a byte address, four times the register index
  localparam int ADDR_W = 10;
  localparam logic [7:0] MAIN_IDX = 8'h8F;
  localparam logic [7:0] SERIAL_IDX = 8'hAF;
  localparam logic [ADDR_W-1:0] MAIN_ADDR = {MAIN_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] SERIAL_ADDR = {SERIAL_IDX, 2'b00};
  // main register fields
  localparam int BIT_DOUBLE_SPEED = 0;
  localparam int BIT_TIMER0 = 1;
  localparam int BIT_TIMER1 = 2;
  localparam int BIT_TIMER2 = 3;
  localparam int BIT_UART = 4;
  localparam int BIT_COUNTER_ARRAY = 5;
  localparam int BIT_WATCHDOG = 6;
  localparam logic [6:1] MAIN_SEL_RESET = 6'h00;
  // serial register field
  localparam int BIT_SPI = 0;
  localparam logic SERIAL_RESET = 1'b0;
  // tick channel order: 0..5 follow main bits 1..6, 6 is spi, 7 is the core
  localparam int CH_UART = 3;
  localparam int CH_CORE = 7;
  localparam int NUM_CH = 8;
  // oscillator periods per cycle
  localparam int PERIODS_STD = 12;
  localparam int PERIODS_FAST = 6;
  localparam int CNT_W = 4;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
endpackage

// file: rtl/rate_divider.sv
// one-cycle tick every 6 or 12 oscillator periods
`timescale 1ns/1ps
`default_nettype none
module rate_divider
  import clk_rate_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic fast_in,
  output logic tick_out
);
  localparam logic [CNT_W-1:0] LAST_STD = CNT_W'(PERIODS_STD - 1);
  localparam logic [CNT_W-1:0] LAST_FAST = CNT_W'(PERIODS_FAST - 1);

  logic [CNT_W-1:0] cnt_ff;
  logic tick_ff;
  wire [CNT_W-1:0] last = fast_in ? LAST_FAST : LAST_STD;
  // a rate change mid-count moves the end of the current cycle; a count already past the new end wraps at the next edge
  wire wrap = (cnt_ff >= last);
  wire [CNT_W-1:0] nxt_cnt = wrap ? '0 : cnt_ff + CNT_W'(1);

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= wrap;
    end
  end

  assign tick_out = tick_ff;
endmodule
`default_nettype wire

// file: testbench/rate_select_properties.sv
// port timing checks for the clock-rate selection block
`timescale 1ns/1ps
`default_nettype none
module rate_select_properties
  import clk_rate_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic [1:0] uart_mode_in,
  input wire logic double_speed_out,
  input wire logic core_tick_out,
  input wire logic [6:0] periph_tick_out,
  input wire logic uart_tick_out
);
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);
  ////////////////////////////////////////////////////////////
  a_bus_answer: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("request not answered");
  a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer longer than one cycle");
  a_read_upper: assert property (
    !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // the shortest period is six, so five quiet cycles are always owed
  a_core_span: assert property (
    core_tick_out |=> !core_tick_out [*5] ##[1:7] core_tick_out)
    else $error("core tick spacing wrong");
  a_spi_span: assert property (periph_tick_out[6] |=> ##[0:11] periph_tick_out[6])
    else $error("spi tick missing");
  a_half_rate: assert property ($changed(double_speed_out) |=> $stable(double_speed_out))
    else $error("double speed changed on adjacent edges");
  a_uart_sel: assert property (
    !$past(uart_mode_in[0]) |-> uart_tick_out == $past(periph_tick_out[3]))
    else $error("uart tick not from uart channel");
  a_uart_core: assert property (
    $past(uart_mode_in[0]) |-> uart_tick_out == $past(core_tick_out))
    else $error("uart tick not from core");
  c_read: cover property (avs_read_in && !avs_waitrequest_out);
  c_fast: cover property ($rose(double_speed_out));
  c_uart: cover property (uart_tick_out && uart_mode_in[0]);
endmodule
bind peripheral_clock_rate_select rate_select_properties rate_select_properties_i (
  .core_clk_in, .resetn_in, .avs_read_in, .avs_write_in, .avs_readdata_out,
  .avs_waitrequest_out, .uart_mode_in, .double_speed_out, .core_tick_out,
  .periph_tick_out, .uart_tick_out);
`default_nettype wire

// file: testbench/peripheral_clock_rate_select_tb.sv
// random and corner-case bench for the clock-rate selection block
`timescale 1ns/1ps
`default_nettype none
module peripheral_clock_rate_select_tb;
  import clk_rate_pkg::*;
  logic core_clk_in = 0, resetn_in = 0, avs_read_in = 0, avs_write_in = 0;
  logic security_double_speed_in = 0;
  logic [ADDR_W-1:0] avs_address_in = '0;
  logic [31:0] avs_writedata_in = '0, avs_readdata_out, rdata;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [1:0] uart_mode_in = 2'h0;
  logic avs_waitrequest_out, double_speed_out, core_tick_out, uart_tick_out;
  logic [6:0] periph_tick_out;
  int n_mismatch = 0, n_checks = 0;
  wire [8:0] ticks = {uart_tick_out, core_tick_out, periph_tick_out};
  peripheral_clock_rate_select peripheral_clock_rate_select_i (.core_clk_in, .resetn_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
    .avs_readdata_out, .avs_waitrequest_out, .security_double_speed_in, .uart_mode_in,
    .double_speed_out, .core_tick_out, .periph_tick_out, .uart_tick_out);
  initial forever #25 core_clk_in = ~core_clk_in;
  ////////////////////////////////////////////////////////////
  task automatic summarize();
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic acc(logic w, logic [ADDR_W-1:0] a, logic [31:0] d, logic [3:0] b);
    int k;
    @(posedge core_clk_in);
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= b;
    for (k = 0; k < 20; k++) begin
      @(posedge core_clk_in);
      if (avs_waitrequest_out === 1'b0) break;
    end
    rdata = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (k == 20) begin
      n_mismatch++;
      summarize();
    end
  endtask
  // cycles between the first two pulses seen; the rate has settled before
  task automatic per(int c, output int n);
    n = -1;
    for (int k = 0; k < 60; k++) begin
      @(posedge core_clk_in);
      if (n >= 0) n++;
      if (ticks[c] === 1'b1) begin
        if (n > 0) break;
        n = 0;
      end
    end
  endtask
  function automatic int exp_per(int c, logic [7:0] m, logic s, logic [1:0] md);
    logic sel;
    if (c == 8) c = md[0] ? CH_CORE : CH_UART;
    sel = c < 6 ? m[c+1] : (c == 6 ? s : 1'b0);
    return (m[0] && !sel) ? PERIODS_FAST : PERIODS_STD;
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] m, s;
    int n;
    void'($urandom(40));
    for (int i = 0; i < 2; i++) begin
      security_double_speed_in <= i[0];
      resetn_in <= 1'b0;
      repeat (8) @(posedge core_clk_in);
      resetn_in <= 1'b1;
      repeat (4) @(posedge core_clk_in);
      acc(1'h0, MAIN_ADDR, 32'h0, 4'hF);
      chk("main_reset", {31'h0, i[0]}, rdata);
      acc(1'h0, SERIAL_ADDR, 32'h0, 4'hF);
      chk("serial_reset", 32'h0, rdata);
    end
    acc(1'h1, MAIN_ADDR, 32'h7E, 4'h0);
    acc(1'h1, 10'h3F0, 32'hFF, 4'hF);
    acc(1'h0, 10'h3F0, 32'h0, 4'hF);
    chk("unmapped", 32'h0, rdata);
    acc(1'h0, MAIN_ADDR, 32'h0, 4'hF);
    chk("no_byte_enable", 32'h1, rdata);
    for (int i = 0; i < 8; i++) begin
      m = i == 0 ? 8'h7E : (i == 1 ? 8'h01 : (i == 2 ? 8'h7F : 8'($urandom) & 8'h7F));
      s = 8'($urandom);
      uart_mode_in <= i < 4 ? 2'(i) : 2'($urandom);
      acc(1'h1, MAIN_ADDR, {24'h0, m}, 4'hF);
      acc(1'h1, SERIAL_ADDR, {24'h0, s}, 4'hF);
      acc(1'h0, MAIN_ADDR, 32'h0, 4'hF);
      chk("main", {24'h0, m}, rdata);
      acc(1'h0, SERIAL_ADDR, 32'h0, 4'hF);
      chk("serial", {31'h0, s[0]}, rdata);
      chk("double_speed", {31'h0, m[0]}, {31'h0, double_speed_out});
      for (int c = 0; c < 9; c++) begin
        per(c, n);
        chk("period", exp_per(c, m, s[0], uart_mode_in), n);
      end
    end
    summarize();
  end
endmodule
`default_nettype wire
